// [inc/eag_pkg.sv]
// package: modes, sizes, widths and request/answer carriers for the address generator
`default_nettype none
package eag_pkg;
  localparam int ADDR_W = 32;
  localparam int REG_IDX_W = 4;
  localparam int NUM_REGS = 16;
  localparam logic [3:0] FIRST_REG_IDX = 4'h0;
  localparam logic [31:0] LONG_ALIGN_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] STEP_BYTE = 32'h00000001;
  localparam logic [31:0] STEP_WORD = 32'h00000002;
  localparam logic [31:0] STEP_LONG = 32'h00000004;
  localparam int TRAP_SHIFT = 2;
  localparam int DISP4_W = 4;
  localparam int DISP8_W = 8;
  localparam int DISP12_W = 12;
  localparam int FIELD_W = 12;

  typedef enum logic [1:0] {
    EAG_SZ_BYTE = 2'h0,
    EAG_SZ_WORD = 2'h1,
    EAG_SZ_LONG = 2'h2
  } eag_size_type;

  typedef enum logic [3:0] {
    EAG_M_REG_DIRECT = 4'h0,
    EAG_M_REG_IND = 4'h1,
    EAG_M_POST_INC = 4'h2,
    EAG_M_PRE_DEC = 4'h3,
    EAG_M_DISP4_REG = 4'h4,
    EAG_M_IDX_REG = 4'h5,
    EAG_M_DISP8_GBASE = 4'h6,
    EAG_M_IDX_GBASE = 4'h7,
    EAG_M_PC_DISP8 = 4'h8,
    EAG_M_BRANCH8 = 4'h9,
    EAG_M_BRANCH12 = 4'hA,
    EAG_M_PC_REG = 4'hB,
    EAG_M_IMM_ZERO = 4'hC,
    EAG_M_IMM_SIGN = 4'hD,
    EAG_M_IMM_TRAP = 4'hE
  } eag_mode_type;

  typedef struct packed {
    eag_mode_type mode;
    eag_size_type size;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [FIELD_W-1:0] field;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] global_base_register;
  } eag_req_type;

  typedef struct packed {
    logic [ADDR_W-1:0] ea;
    logic ea_valid;
    logic [ADDR_W-1:0] operand;
    logic operand_valid;
    logic wb_en;
    logic [REG_IDX_W-1:0] wb_idx;
    logic [ADDR_W-1:0] wb_data;
  } eag_rsp_type;
endpackage
`default_nettype wire

// [verilog/eag_regfile.sv]
// general register file: sixteen words, two registered read ports, one write port
`timescale 1ns/10ps
`default_nettype none
module eag_regfile (
  input wire logic mclk_in,
  input wire logic we_in,
  input wire logic [3:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] raddr_a_in,
  input wire logic [3:0] raddr_b_in,
  output logic [31:0] rdata_a_out,
  output logic [31:0] rdata_b_out
);
  logic [31:0] mem_r [0:eag_pkg::NUM_REGS-1];

  // write-first so a back-to-back update reads the new value
  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    rdata_a_out <= (we_in && waddr_in == raddr_a_in) ? wdata_in : mem_r[raddr_a_in];
    rdata_b_out <= (we_in && waddr_in == raddr_b_in) ? wdata_in : mem_r[raddr_b_in];
  end
endmodule
`default_nettype wire

// [verilog/eag_top.sv]
// effective address generator: address, write-back and immediate operand datapath
`timescale 1ns/10ps
`default_nettype none
module eag_top (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic req_valid_in,
  input wire eag_pkg::eag_req_type req_in,
  input wire logic ext_we_in,
  input wire logic [3:0] ext_waddr_in,
  input wire logic [31:0] ext_wdata_in,
  output eag_pkg::eag_rsp_type rsp_out
);
  // ----------------------------------------
  // stage 1: capture request, read registers
  // ----------------------------------------
  eag_pkg::eag_req_type req_r;
  logic req_valid_r;
  logic [31:0] sel_reg;
  logic [31:0] first_reg;
  logic rf_we;
  logic [3:0] rf_waddr;
  logic [31:0] rf_wdata;
  eag_pkg::eag_rsp_type rsp_nxt;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      req_valid_r <= 1'b0;
      req_r <= '0;
    end else begin
      req_valid_r <= req_valid_in;
      req_r <= req_in;
    end
  end

  // own write-back has priority over the external port; the decoder must not collide
  assign rf_we = rsp_nxt.wb_en || ext_we_in;
  assign rf_waddr = rsp_nxt.wb_en ? rsp_nxt.wb_idx : ext_waddr_in;
  assign rf_wdata = rsp_nxt.wb_en ? rsp_nxt.wb_data : ext_wdata_in;

  eag_regfile u_regfile (
    .mclk_in(mclk_in),
    .we_in(rf_we),
    .waddr_in(rf_waddr),
    .wdata_in(rf_wdata),
    .raddr_a_in(req_in.reg_idx),
    .raddr_b_in(eag_pkg::FIRST_REG_IDX),
    .rdata_a_out(sel_reg),
    .rdata_b_out(first_reg)
  );

  // ----------------------------------------
  // stage 2: address arithmetic
  // ----------------------------------------
  logic [31:0] step;
  logic [1:0] scale_sh;
  logic [31:0] d4_zx;
  logic [31:0] d8_zx;
  logic [31:0] d8_sx;
  logic [31:0] d12_sx;
  logic [31:0] pc_base;

  always_comb begin
    case (req_r.size)
      eag_pkg::EAG_SZ_WORD: begin
        step = eag_pkg::STEP_WORD;
        scale_sh = 2'h1;
      end
      eag_pkg::EAG_SZ_LONG: begin
        step = eag_pkg::STEP_LONG;
        scale_sh = 2'h2;
      end
      default: begin
        step = eag_pkg::STEP_BYTE;
        scale_sh = 2'h0;
      end
    endcase
  end

  assign d4_zx = {28'h0000000, req_r.field[eag_pkg::DISP4_W-1:0]};
  assign d8_zx = {24'h000000, req_r.field[eag_pkg::DISP8_W-1:0]};
  assign d8_sx = {{24{req_r.field[eag_pkg::DISP8_W-1]}}, req_r.field[eag_pkg::DISP8_W-1:0]};
  assign d12_sx = {{20{req_r.field[eag_pkg::DISP12_W-1]}}, req_r.field};
  // long operands read from a 4-byte-aligned pc; word and byte reads use pc as is
  assign pc_base = (req_r.size == eag_pkg::EAG_SZ_LONG) ?
                   (req_r.pc & eag_pkg::LONG_ALIGN_MASK) : req_r.pc;

  // 32-bit targets throughout: carries beyond bit 31 fall away
  always_comb begin
    rsp_nxt = '0;
    if (req_valid_r) begin
      case (req_r.mode)
        eag_pkg::EAG_M_REG_DIRECT: begin
          rsp_nxt.operand = sel_reg;
          rsp_nxt.operand_valid = 1'b1;
        end
        eag_pkg::EAG_M_REG_IND: begin
          rsp_nxt.ea = sel_reg;
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_POST_INC: begin
          rsp_nxt.ea = sel_reg;
          rsp_nxt.ea_valid = 1'b1;
          rsp_nxt.wb_en = 1'b1;
          rsp_nxt.wb_idx = req_r.reg_idx;
          rsp_nxt.wb_data = sel_reg + step;
        end
        eag_pkg::EAG_M_PRE_DEC: begin
          rsp_nxt.ea = sel_reg - step;
          rsp_nxt.ea_valid = 1'b1;
          rsp_nxt.wb_en = 1'b1;
          rsp_nxt.wb_idx = req_r.reg_idx;
          rsp_nxt.wb_data = sel_reg - step;
        end
        eag_pkg::EAG_M_DISP4_REG: begin
          rsp_nxt.ea = sel_reg + (d4_zx << scale_sh);
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_IDX_REG: begin
          rsp_nxt.ea = sel_reg + first_reg;
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_DISP8_GBASE: begin
          rsp_nxt.ea = req_r.global_base_register + (d8_zx << scale_sh);
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_IDX_GBASE: begin
          rsp_nxt.ea = req_r.global_base_register + first_reg;
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_PC_DISP8: begin
          // byte size is not a legal pc-relative form; treated as word scaling
          rsp_nxt.ea = (req_r.size == eag_pkg::EAG_SZ_LONG) ?
                       pc_base + (d8_zx << 2) : pc_base + (d8_zx << 1);
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_BRANCH8: begin
          rsp_nxt.ea = req_r.pc + (d8_sx << 1);
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_BRANCH12: begin
          rsp_nxt.ea = req_r.pc + (d12_sx << 1);
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_PC_REG: begin
          rsp_nxt.ea = req_r.pc + sel_reg;
          rsp_nxt.ea_valid = 1'b1;
        end
        eag_pkg::EAG_M_IMM_ZERO: begin
          rsp_nxt.operand = d8_zx;
          rsp_nxt.operand_valid = 1'b1;
        end
        eag_pkg::EAG_M_IMM_SIGN: begin
          rsp_nxt.operand = d8_sx;
          rsp_nxt.operand_valid = 1'b1;
        end
        eag_pkg::EAG_M_IMM_TRAP: begin
          rsp_nxt.operand = d8_zx << eag_pkg::TRAP_SHIFT;
          rsp_nxt.operand_valid = 1'b1;
        end
        default: begin
          rsp_nxt = '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // stage 3: registered answer
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out <= rsp_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_post_inc;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_POST_INC)
      |=> (rsp_out.ea == $past(sel_reg) && rsp_out.wb_data == $past(sel_reg) + $past(step));
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-increment wrong");

  property p_pre_dec;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_PRE_DEC)
      |=> (rsp_out.wb_en && rsp_out.ea == rsp_out.wb_data &&
           rsp_out.wb_data == $past(sel_reg) - $past(step));
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement address differs");

  property p_reg_ind;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_REG_IND)
      |=> (!rsp_out.wb_en && rsp_out.ea_valid && rsp_out.ea == $past(sel_reg));
  endproperty
  a_reg_ind: assert property (p_reg_ind) else $error("indirect mode wrong");

  property p_direct;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_REG_DIRECT)
      |=> (!rsp_out.ea_valid && rsp_out.operand == $past(sel_reg));
  endproperty
  a_direct: assert property (p_direct) else $error("direct operand wrong");

  property p_pc_long;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_PC_DISP8 && req_r.size == eag_pkg::EAG_SZ_LONG)
      |=> (rsp_out.ea[1:0] == 2'h0);
  endproperty
  a_pc_long: assert property (p_pc_long) else $error("long pc-relative unaligned");

  property p_branch;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_BRANCH8)
      |=> (rsp_out.ea[0] == $past(req_r.pc[0]));
  endproperty
  a_branch: assert property (p_branch) else $error("branch parity wrong");

  property p_imm_zero;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_IMM_ZERO)
      |=> (rsp_out.operand_valid && rsp_out.operand == {24'h000000, $past(req_r.field[7:0])});
  endproperty
  a_imm_zero: assert property (p_imm_zero) else $error("zero extension wrong");

  property p_trap;
    @(posedge mclk_in) disable iff (reset_in)
    (req_valid_r && req_r.mode == eag_pkg::EAG_M_IMM_TRAP)
      |=> (rsp_out.operand == {22'h000000, $past(req_r.field[7:0]), 2'h0});
  endproperty
  a_trap: assert property (p_trap) else $error("trap offset wrong");

  property p_idle;
    @(posedge mclk_in) disable iff (reset_in)
    !req_valid_r |=> (!rsp_out.ea_valid && !rsp_out.operand_valid && !rsp_out.wb_en);
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
endmodule
`default_nettype wire

// [tb/eag_lsu_model.sv]
// load/store side model: captures every answer of the address generator
`timescale 1ns/10ps
`default_nettype none
module eag_lsu_model (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire eag_pkg::eag_rsp_type rsp_in,
  output logic got_out,
  output eag_pkg::eag_rsp_type seen_out
);
  // answers stand one cycle only, so every edge is sampled
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      got_out <= 1'b0;
      seen_out <= '0;
    end else begin
      got_out <= rsp_in.ea_valid | rsp_in.operand_valid | rsp_in.wb_en;
      seen_out <= rsp_in;
    end
  end
endmodule
`default_nettype wire

// [tb/eag_top_tb_top.sv]
// self-checking bench for the effective address generator
`timescale 1ns/10ps
`default_nettype none
module eag_top_tb_top;
  logic mclk_in;
  logic reset_in;
  logic req_valid_in;
  eag_pkg::eag_req_type req_in;
  logic ext_we_in;
  logic [3:0] ext_waddr_in;
  logic [31:0] ext_wdata_in;
  eag_pkg::eag_rsp_type rsp_out;
  eag_pkg::eag_rsp_type seen;
  logic got;
  logic [31:0] rf [16];
  eag_pkg::eag_rsp_type exp_q [$];
  int n_fail = 0;
  int total_checks = 0;

  eag_top uut (.mclk_in(mclk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .ext_we_in(ext_we_in), .ext_waddr_in(ext_waddr_in),
    .ext_wdata_in(ext_wdata_in), .rsp_out(rsp_out));
  eag_lsu_model lsu (.mclk_in(mclk_in), .reset_in(reset_in), .rsp_in(rsp_out),
    .got_out(got), .seen_out(seen));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [102:0] got_v, input logic [102:0] exp_v);
    total_checks++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got_v, exp_v);
    end
  endtask

  // expected answer from the shadow registers; sums wrap at 32 bits
  function automatic eag_pkg::eag_rsp_type expect_of(input eag_pkg::eag_req_type q);
    eag_pkg::eag_rsp_type e;
    logic [31:0] r;
    logic [31:0] sc;
    logic [31:0] f8;
    e = '0;
    r = rf[q.reg_idx];
    f8 = {24'h000000, q.field[7:0]};
    sc = (q.size == eag_pkg::EAG_SZ_LONG) ? 32'h00000004 :
      (q.size == eag_pkg::EAG_SZ_WORD) ? 32'h00000002 : 32'h00000001;
    e.ea_valid = 1'b1;
    case (q.mode)
      eag_pkg::EAG_M_REG_DIRECT: begin
        e.ea_valid = 1'b0;
        e.operand_valid = 1'b1;
        e.operand = r;
      end
      eag_pkg::EAG_M_REG_IND: e.ea = r;
      eag_pkg::EAG_M_POST_INC, eag_pkg::EAG_M_PRE_DEC: begin
        e.wb_en = 1'b1;
        e.wb_idx = q.reg_idx;
        e.wb_data = (q.mode == eag_pkg::EAG_M_POST_INC) ? r + sc : r - sc;
        e.ea = (q.mode == eag_pkg::EAG_M_POST_INC) ? r : e.wb_data;
      end
      eag_pkg::EAG_M_DISP4_REG: e.ea = r + {28'h0000000, q.field[3:0]} * sc;
      eag_pkg::EAG_M_IDX_REG: e.ea = r + rf[0];
      eag_pkg::EAG_M_DISP8_GBASE: e.ea = q.global_base_register + f8 * sc;
      eag_pkg::EAG_M_IDX_GBASE: e.ea = q.global_base_register + rf[0];
      eag_pkg::EAG_M_PC_DISP8: begin
        if (q.size == eag_pkg::EAG_SZ_LONG) e.ea = (q.pc & 32'hFFFFFFFC) + (f8 << 2);
        else e.ea = q.pc + (f8 << 1);
      end
      eag_pkg::EAG_M_BRANCH8: e.ea = q.pc + ({{24{q.field[7]}}, q.field[7:0]} << 1);
      eag_pkg::EAG_M_BRANCH12: e.ea = q.pc + ({{20{q.field[11]}}, q.field} << 1);
      eag_pkg::EAG_M_PC_REG: e.ea = q.pc + r;
      eag_pkg::EAG_M_IMM_ZERO, eag_pkg::EAG_M_IMM_SIGN, eag_pkg::EAG_M_IMM_TRAP: begin
        e.ea_valid = 1'b0;
        e.operand_valid = 1'b1;
        e.operand = f8;
        if (q.mode == eag_pkg::EAG_M_IMM_SIGN) e.operand = {{24{q.field[7]}}, q.field[7:0]};
        if (q.mode == eag_pkg::EAG_M_IMM_TRAP) e.operand = f8 << 2;
      end
      default: e.ea_valid = 1'b0;
    endcase
    return e;
  endfunction

  // b2b keeps valid up so the next request is taken at the very next edge
  task automatic issue(input eag_pkg::eag_req_type q, input bit b2b);
    eag_pkg::eag_rsp_type e;
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_in <= q;
    e = expect_of(q);
    if (e.ea_valid | e.operand_valid) exp_q.push_back(e);
    if (e.wb_en) rf[e.wb_idx] = e.wb_data;
    if (!b2b) begin
      @(posedge mclk_in);
      req_valid_in <= 1'b0;
    end
  endtask

  function automatic eag_pkg::eag_req_type rand_req(input bit no_wb);
    eag_pkg::eag_req_type q;
    q.mode = eag_pkg::eag_mode_type'(4'($urandom_range(0, 15)));
    if (no_wb && (q.mode == eag_pkg::EAG_M_POST_INC || q.mode == eag_pkg::EAG_M_PRE_DEC))
      q.mode = eag_pkg::EAG_M_IDX_REG;
    q.size = eag_pkg::eag_size_type'(2'($urandom_range(0, 3)));
    q.reg_idx = 4'($urandom_range(0, 15));
    q.field = 12'($urandom);
    q.pc = $urandom;
    q.global_base_register = $urandom;
    return q;
  endfunction

  // watcher: oldest note is compared with each answer the load/store side saw
  always @(negedge mclk_in) begin
    if (got) begin
      if (exp_q.size() == 0) check(seen, '0);
      else begin
        eag_pkg::eag_rsp_type e;
        e = exp_q.pop_front();
        check({seen.ea_valid, seen.operand_valid, seen.wb_en},
          {e.ea_valid, e.operand_valid, e.wb_en});
        if (e.ea_valid) check(seen.ea, e.ea);
        if (e.operand_valid) check(seen.operand, e.operand);
        if (e.wb_en) check({seen.wb_idx, seen.wb_data}, {e.wb_idx, e.wb_data});
      end
    end
  end

  initial begin
    repeat (6000) @(posedge mclk_in);
    n_fail++;
    end_of_test();
  end

  initial begin
    int i;
    reset_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '0;
    ext_we_in = 1'b0;
    ext_waddr_in = 4'h0;
    ext_wdata_in = 32'h00000000;
    void'($urandom(91456));
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(negedge mclk_in);
    check(rsp_out, '0);
    for (i = 0; i < 16; i++) begin
      @(posedge mclk_in);
      rf[i] = (i == 1) ? 32'hFFFFFFFE : $urandom;
      ext_we_in <= 1'b1;
      ext_waddr_in <= 4'(i);
      ext_wdata_in <= rf[i];
    end
    @(posedge mclk_in);
    ext_we_in <= 1'b0;
    // every mode and size, spaced for dependent write-backs
    for (i = 0; i < 64; i++) begin
      eag_pkg::eag_req_type q;
      q = rand_req(1'b0);
      q.mode = eag_pkg::eag_mode_type'(4'(i));
      q.size = eag_pkg::eag_size_type'(2'(i >> 4));
      q.reg_idx = (i[0]) ? 4'h1 : q.reg_idx;
      issue(q, 1'b0);
    end
    for (i = 0; i < 150; i++) issue(rand_req(1'b0), 1'b0);
    // reset in mid-run clears the answer; register contents survive, so the shadow stays valid
    for (i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(negedge mclk_in);
    check(rsp_out, '0);
    for (i = 0; i < 40; i++) issue(rand_req(1'b1), i != 39);
    for (i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge mclk_in);
    if (exp_q.size() != 0) n_fail++;
    repeat (3) @(posedge mclk_in);
    end_of_test();
  end
endmodule
`default_nettype wire
